// >>> include/sss_pkg.sv
/*
 * Constants, types and timing for the supervisor serial slave.
 * Assumes a 40 MHz system clock and a 32.768 kHz crystal time base
 * arriving as a plain pin that is sampled by the system clock.
 */
// Function
// [R01] watchdog select 00=1.75 s, 01=750 ms, 10=250 ms, 11=off and idle
// [R02] status write of 02h sets write enable latch at once, no delay
// [R03] status write of 06h then sets register write latch and write enable latch
// [R04] with both latches set, one to eight bytes go to control registers
// [R05] completed control register write starts a nonvolatile cycle of at most 10 ms
// [R06] data aimed at undefined control addresses changes nothing
// [R07] end of nonvolatile cycle clears the register write latch
// [R08] incomplete register write leaves register write latch set, device active
// [R09] status write of zero clears both latches
// [R10] reads between sequence steps leave latch state untouched
// [R11] reset output active at power-up until supply above trip for 250 ms
// [R12] every start condition reloads watchdog to its full selected period
// [R13] watchdog running out asserts the reset output
// [R14] start conditions during a reset timeout do not touch the watchdog
// [R15] low voltage: nonvolatile cycle finishes, serial transfer aborted, commands refused
// [R16] programming voltage plus 00h to 01h raises trip threshold at stop
// [R17] programming voltage plus 00h to 03h restores native trip threshold at stop
// [R18] data changes only while serial clock low; high-clock changes mark start/stop
// [R19] bus ignored until start; stop after read returns to standby
// [R20] write data bytes not acknowledged while write enable latch clear
// [R21] second data byte of a status register write is not acknowledged
// [R22] reads: eight bits, release, sample ack; continue on ack, stop on none
// [R23] status register sits at serial address 3Fh
// [R24] watchdog and power-on timing count crystal ticks, not serial clock
package sss_pkg;

	// ---------------------------------------------------------------
	// time base
	// ---------------------------------------------------------------
	localparam int XTAL_HZ     = 32768;
	localparam int WD_LONG_MS  = 1750;
	localparam int WD_MID_MS   = 750;
	localparam int WD_SHORT_MS = 250;
	localparam int POR_MS      = 250;
	localparam int NV_WRITE_MS = 10;
	localparam int TICK_W      = 16;

	// least times round up, the longest write time rounds down
	localparam logic [TICK_W-1:0] WD_LONG_TICKS  = TICK_W'((WD_LONG_MS * XTAL_HZ + 999) / 1000);
	localparam logic [TICK_W-1:0] WD_MID_TICKS   = TICK_W'((WD_MID_MS * XTAL_HZ + 999) / 1000);
	localparam logic [TICK_W-1:0] WD_SHORT_TICKS = TICK_W'((WD_SHORT_MS * XTAL_HZ + 999) / 1000);
	localparam logic [TICK_W-1:0] POR_TICKS      = TICK_W'((POR_MS * XTAL_HZ + 999) / 1000);
	localparam logic [TICK_W-1:0] NV_TICKS       = TICK_W'(NV_WRITE_MS * XTAL_HZ / 1000);

	// ---------------------------------------------------------------
	// serial address space
	// ---------------------------------------------------------------
	localparam logic [5:0] SR_ADDR       = 6'h3F;
	localparam logic [5:0] CTRL_ADDR     = 6'h10;
	localparam logic [5:0] CCR_LAST_ADDR = 6'h13;
	localparam logic [5:0] RTC_FIRST     = 6'h30;
	localparam logic [5:0] RTC_LAST      = 6'h37;
	localparam logic [5:0] TRIP_SET_ADDR = 6'h01;
	localparam logic [5:0] TRIP_CLR_ADDR = 6'h03;
	localparam logic [7:0] TRIP_DATA     = 8'h00;
	localparam int         WD_HI_BIT     = 3;
	localparam int         WD_LO_BIT     = 2;
	localparam int         PAGE_BYTES    = 8;
	localparam logic [7:0] CCR_RESET     = 8'h00;
	localparam logic [7:0] SR_SET_WEL    = 8'h02;
	localparam logic [7:0] SR_SET_REGISTER_WRITE_LATCH   = 8'h06;
	localparam logic [7:0] SR_CLEAR      = 8'h00;
	localparam logic [1:0] WD_OFF        = 2'b11;

	// ---------------------------------------------------------------
	// bus registers
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam int         CTRL_SUPPLY   = 0;
	localparam int         CTRL_PROG     = 1;
	localparam logic [1:0] CTRL_RESET    = 2'h1;

	typedef enum logic [1:0] {
		PH_SLAVE,
		PH_ADDR_HI,
		PH_ADDR_LO,
		PH_DATA
	} sss_phase_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} sss_ahb_req_t;

	typedef struct packed {
		logic trip_high;
		logic nv_busy;
		logic rst_active;
		logic wd_off;
		logic register_write_latch;
		logic write_enable_latch;
	} sss_status_t;

endpackage

// >>> design/sss_sync.sv
/*
 * Two-flop synchroniser for a group of pins.
 * Assumes the pins idle high, as the serial lines do with pull-ups.
 */
`timescale 1ns/1ps
module sss_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_reg <= '1;
			q_o      <= '1;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule

// >>> design/sss_serial_slave.sv
/*
 * Supervisor serial slave: two-wire slave, write latches, nonvolatile
 * write timer, watchdog, power-on/low-voltage reset and trip programming.
 * Assumes an AHB-Lite master, open-drain lines resolved outside, and a
 * crystal tick pin; supply and programming voltage come from a bus register.
 */
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sss_serial_slave
	import sss_pkg::*;
#(
	parameter logic [6:0]        SLAVE_ID       = 7'h2A,
	parameter logic [TICK_W-1:0] WD_LONG_TICKS  = sss_pkg::WD_LONG_TICKS,
	parameter logic [TICK_W-1:0] WD_MID_TICKS   = sss_pkg::WD_MID_TICKS,
	parameter logic [TICK_W-1:0] WD_SHORT_TICKS = sss_pkg::WD_SHORT_TICKS,
	parameter logic [TICK_W-1:0] POR_TICKS      = sss_pkg::POR_TICKS,
	parameter logic [TICK_W-1:0] NV_TICKS       = sss_pkg::NV_TICKS
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        xtal_i,
	output logic             reset_out_o,
	output logic             reset_out_oe_o
);
	// SLAVE_ID default is arbitrary

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_RACK
	} sss_state_t;

	function automatic logic [TICK_W-1:0] wd_period(input logic [1:0] sel);
		case (sel)
			2'b00:   wd_period = WD_LONG_TICKS;
			2'b01:   wd_period = WD_MID_TICKS;
			2'b10:   wd_period = WD_SHORT_TICKS;
			default: wd_period = '0;
		endcase
	endfunction

	function automatic logic ccr_defined(input logic [5:0] a);
		ccr_defined = (a <= CCR_LAST_ADDR) || (a >= RTC_FIRST && a <= RTC_LAST);
	endfunction

	// ---------------------------------------------------------------
	// pin sampling and bus events
	// ---------------------------------------------------------------
	logic [2:0] sync_q;
	logic       scl_q_reg;
	logic       sda_q_reg;
	logic       xtal_q_reg;

	sss_sync #(.WIDTH(3)) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.d_i     ({xtal_i, sda_i, scl_i}),
		.q_o     (sync_q)
	);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			scl_q_reg  <= 1'b1;
			sda_q_reg  <= 1'b1;
			xtal_q_reg <= 1'b1;
		end else begin
			scl_q_reg  <= sync_q[0];
			sda_q_reg  <= sync_q[1];
			xtal_q_reg <= sync_q[2];
		end
	end

	wire scl_s      = sync_q[0];
	wire sda_s      = sync_q[1];
	wire scl_rise_w = scl_s & ~scl_q_reg;
	wire scl_fall_w = ~scl_s & scl_q_reg;
	// only high-clock data edges count as framing [R18]
	wire start_w    = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
	wire stop_w     = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
	// crystal edges time everything slow [R24]
	wire tick_w     = sync_q[2] & ~xtal_q_reg;

	// ---------------------------------------------------------------
	// bus registers (zero wait, always OKAY)
	// ---------------------------------------------------------------
	sss_ahb_req_t ap_reg;
	logic [1:0]   ctrl_reg;
	sss_status_t  stat_w;

	wire ap_take_w = hsel_i & htrans_i[1] & hready_i;
	wire supply_ok_w = ctrl_reg[CTRL_SUPPLY];
	wire prog_w      = ctrl_reg[CTRL_PROG];
	wire lvr_w       = ~supply_ok_w;
	wire [31:0] rd_mux_w = (haddr_i[7:0] == REG_CTRL)   ? {30'h0, ctrl_reg} :
	                       (haddr_i[7:0] == REG_STATUS) ? {26'h0, stat_w} : 32'h0;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ap_reg   <= '0;
			ctrl_reg <= CTRL_RESET;
			hrdata_o <= 32'h0;
		end else begin
			ap_reg <= '{valid: ap_take_w, write: hwrite_i, addr: haddr_i[7:0]};
			if (ap_take_w && !hwrite_i)
				hrdata_o <= rd_mux_w;
			if (ap_reg.valid && ap_reg.write && ap_reg.addr == REG_CTRL)
				ctrl_reg <= hwdata_i[1:0];
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// ---------------------------------------------------------------
	// serial slave
	// ---------------------------------------------------------------
	sss_state_t  state_reg;
	sss_phase_t  phase_reg;
	logic [3:0]  bit_cnt_reg;
	logic [3:0]  data_cnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  tx_reg;
	logic        rw_reg;
	logic        m_ack_reg;
	logic        sr_tgt_reg;
	logic [5:0]  addr_reg;
	logic [2:0]  base_reg;
	logic [2:0]  widx_reg;
	logic [7:0]  sr_data_reg;
	logic [7:0]  buf_reg [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] vld_reg;
	logic        wel_reg;
	logic        register_write_latch_reg;
	logic        nv_busy_w;
	logic [7:0]  ccr_mem [64];

	wire [7:0] sr_read_w = {5'h00, register_write_latch_reg, wel_reg, 1'b0};
	wire [7:0] rd_byte_w = (addr_reg == SR_ADDR) ? sr_read_w : ccr_mem[addr_reg]; // [R23]
	wire id_ok_w = (shift_reg[7:1] == SLAVE_ID) && !nv_busy_w;
	// write data needs the enable latch; status takes one byte only [R20] [R21]
	wire data_ack_w = sr_tgt_reg ? (data_cnt_reg == 4'h0) : wel_reg;
	wire ack_w = (phase_reg == PH_SLAVE) ? id_ok_w :
	             (phase_reg == PH_DATA)  ? data_ack_w : 1'b1;
	// the stop's own clock high is shifted in as one stray bit before the stop shows
	wire wr_done_w = (state_reg == ST_RX) && (phase_reg == PH_DATA) && !rw_reg
	               && (bit_cnt_reg == 4'h1) && (data_cnt_reg != 4'h0);
	wire commit_sr_w  = stop_w && !lvr_w && wr_done_w && sr_tgt_reg;
	wire commit_ccr_w = stop_w && !lvr_w && wr_done_w && !sr_tgt_reg && wel_reg && register_write_latch_reg; // [R04]

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg    <= ST_IDLE;
			phase_reg    <= PH_SLAVE;
			bit_cnt_reg  <= 4'h0;
			data_cnt_reg <= 4'h0;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'h00;
			rw_reg       <= 1'b0;
			m_ack_reg    <= 1'b0;
			sr_tgt_reg   <= 1'b0;
			addr_reg     <= 6'h00;
			base_reg     <= 3'h0;
			widx_reg     <= 3'h0;
			sr_data_reg  <= 8'h00;
			vld_reg      <= '0;
			sda_oe_o     <= 1'b0;
		end else if (lvr_w) begin
			state_reg <= ST_IDLE; // [R15]
			sda_oe_o  <= 1'b0;
		end else if (start_w) begin
			// a repeated start drops buffered data, latches untouched [R08]
			state_reg    <= ST_RX;
			phase_reg    <= PH_SLAVE;
			bit_cnt_reg  <= 4'h0;
			data_cnt_reg <= 4'h0;
			vld_reg      <= '0;
			sda_oe_o     <= 1'b0;
		end else if (stop_w) begin
			state_reg <= ST_IDLE; // [R19]
			sda_oe_o  <= 1'b0;
		end else begin
			case (state_reg)
				ST_RX: begin
					if (scl_rise_w && bit_cnt_reg != 4'h8) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall_w && bit_cnt_reg == 4'h8) begin
						bit_cnt_reg <= 4'h0;
						state_reg   <= ST_ACK;
						sda_oe_o    <= ack_w; // [R18]
						case (phase_reg)
							PH_SLAVE: begin
								rw_reg <= shift_reg[0];
								if (!shift_reg[0])
									phase_reg <= PH_ADDR_HI;
							end
							PH_ADDR_HI: phase_reg <= PH_ADDR_LO;
							PH_ADDR_LO: begin
								phase_reg  <= PH_DATA;
								addr_reg   <= shift_reg[5:0];
								base_reg   <= shift_reg[5:3];
								widx_reg   <= shift_reg[2:0];
								sr_tgt_reg <= (shift_reg[5:0] == SR_ADDR);
							end
							default: begin
								if (ack_w && sr_tgt_reg)
									sr_data_reg <= shift_reg;
								if (ack_w && !sr_tgt_reg) begin
									// page index wraps, later bytes overwrite
									buf_reg[widx_reg] <= shift_reg;
									vld_reg[widx_reg] <= 1'b1;
									widx_reg          <= widx_reg + 3'h1;
								end
								if (data_cnt_reg != 4'hF)
									data_cnt_reg <= data_cnt_reg + 4'h1;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall_w) begin
						if (!sda_oe_o) begin
							state_reg <= ST_IDLE;
						end else if (rw_reg) begin
							tx_reg      <= rd_byte_w;
							sda_oe_o    <= ~rd_byte_w[7];
							bit_cnt_reg <= 4'h1;
							addr_reg    <= addr_reg + 6'h01;
							state_reg   <= ST_TX;
						end else begin
							sda_oe_o  <= 1'b0;
							state_reg <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall_w) begin
						if (bit_cnt_reg == 4'h8) begin
							sda_oe_o  <= 1'b0; // [R22]
							state_reg <= ST_RACK;
						end else begin
							tx_reg      <= {tx_reg[6:0], 1'b0};
							sda_oe_o    <= ~tx_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise_w)
						m_ack_reg <= ~sda_s;
					else if (scl_fall_w && m_ack_reg) begin
						tx_reg      <= rd_byte_w; // [R22]
						sda_oe_o    <= ~rd_byte_w[7];
						bit_cnt_reg <= 4'h1;
						addr_reg    <= addr_reg + 6'h01;
						state_reg   <= ST_TX;
					end else if (scl_fall_w)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign sda_o = 1'b0;

	// ---------------------------------------------------------------
	// write latches and nonvolatile cycle
	// ---------------------------------------------------------------
	logic [TICK_W-1:0] nv_cnt_reg;
	logic              trip_high_reg;

	assign nv_busy_w = (nv_cnt_reg != '0);
	wire nv_done_w = nv_busy_w && tick_w && (nv_cnt_reg == TICK_W'(1));

	// only serial writes and the end of a nonvolatile cycle reach the latches, so reads never disturb them [R10]
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wel_reg  <= 1'b0;
			register_write_latch_reg <= 1'b0;
		end else if (nv_done_w) begin
			register_write_latch_reg <= 1'b0; // [R07]
		end else if (commit_sr_w) begin
			if (sr_data_reg == SR_SET_WEL)
				wel_reg <= 1'b1; // [R02]
			else if (sr_data_reg == SR_SET_REGISTER_WRITE_LATCH && wel_reg) begin
				wel_reg  <= 1'b1; // [R03]
				register_write_latch_reg <= 1'b1;
			end else if (sr_data_reg == SR_CLEAR) begin
				wel_reg  <= 1'b0; // [R09]
				register_write_latch_reg <= 1'b0;
			end
		end
	end

	// cycle keeps running under low voltage, only new commits are refused
	always_ff @(posedge clk_i) begin
		if (reset_i)
			nv_cnt_reg <= '0;
		else if (commit_ccr_w)
			nv_cnt_reg <= NV_TICKS; // [R05]
		else if (nv_busy_w && tick_w)
			nv_cnt_reg <= nv_cnt_reg - TICK_W'(1); // [R15]
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 64; i++)
				ccr_mem[i] <= CCR_RESET;
			trip_high_reg <= 1'b0;
		end else if (commit_ccr_w) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (vld_reg[i] && ccr_defined({base_reg, 3'(i)}))
					ccr_mem[{base_reg, 3'(i)}] <= buf_reg[i]; // [R06]
				if (vld_reg[i] && prog_w && buf_reg[i] == TRIP_DATA) begin
					if ({base_reg, 3'(i)} == TRIP_SET_ADDR)
						trip_high_reg <= 1'b1; // [R16]
					else if ({base_reg, 3'(i)} == TRIP_CLR_ADDR)
						trip_high_reg <= 1'b0; // [R17]
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// watchdog and reset output
	// ---------------------------------------------------------------
	logic [TICK_W-1:0] wd_cnt_reg;
	logic [TICK_W-1:0] rst_cnt_reg;
	logic              rst_active_reg;

	wire [1:0] wd_sel_w = ccr_mem[CTRL_ADDR][WD_HI_BIT:WD_LO_BIT];
	wire [TICK_W-1:0] wd_period_w = wd_period(wd_sel_w); // [R01]
	wire wd_on_w = (wd_sel_w != WD_OFF);
	wire rst_busy_w = (rst_cnt_reg != '0) || lvr_w;
	wire wd_expire_w = !rst_busy_w && wd_on_w && tick_w && (wd_cnt_reg == TICK_W'(1));

	// off setting parks the counter so nothing toggles [R01]
	always_ff @(posedge clk_i) begin
		if (reset_i)
			wd_cnt_reg <= WD_LONG_TICKS;
		else if (rst_busy_w || !wd_on_w)
			wd_cnt_reg <= wd_period_w; // [R14]
		else if (start_w)
			wd_cnt_reg <= wd_period_w; // [R12]
		else if (tick_w && wd_cnt_reg != '0)
			wd_cnt_reg <= wd_cnt_reg - TICK_W'(1);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			rst_cnt_reg <= POR_TICKS;
		else if (lvr_w || wd_expire_w)
			rst_cnt_reg <= POR_TICKS; // [R11] [R13]
		else if (tick_w && rst_cnt_reg != '0)
			rst_cnt_reg <= rst_cnt_reg - TICK_W'(1);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			rst_active_reg <= 1'b1;
		else
			rst_active_reg <= rst_busy_w;
	end

	assign reset_out_o    = 1'b0;
	assign reset_out_oe_o = rst_active_reg;
	assign stat_w = '{trip_high: trip_high_reg, nv_busy: nv_busy_w, rst_active: rst_active_reg,
	                  wd_off: !wd_on_w, register_write_latch: register_write_latch_reg, write_enable_latch: wel_reg};

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	chk_sr_set_wel: assert property (commit_sr_w && sr_data_reg == SR_SET_WEL && !nv_done_w |=> wel_reg) // [R02]
		else $error("status 02h did not set write enable");
	chk_sr_set_register_write_latch: assert property (commit_sr_w && sr_data_reg == SR_SET_REGISTER_WRITE_LATCH && wel_reg && !nv_done_w
		|=> register_write_latch_reg && wel_reg) // [R03]
		else $error("status 06h did not set both latches");
	chk_sr_clear: assert property (commit_sr_w && sr_data_reg == SR_CLEAR |=> !wel_reg && !register_write_latch_reg) // [R09]
		else $error("status zero did not clear latches");
	chk_nv_start: assert property ($rose(nv_busy_w) |-> $past(commit_ccr_w) && nv_cnt_reg == NV_TICKS) // [R05]
		else $error("nonvolatile cycle started without a commit");
	chk_nv_register_write_latch_clear: assert property (nv_done_w |=> !register_write_latch_reg && !nv_busy_w) // [R07]
		else $error("register write latch survived cycle end");
	chk_wd_restart: assert property (start_w && !rst_busy_w && wd_on_w |=> wd_cnt_reg == $past(wd_period_w)) // [R12]
		else $error("start did not reload watchdog");
	chk_wd_expire: assert property (wd_expire_w |=> rst_busy_w ##1 rst_active_reg) // [R13]
		else $error("watchdog expiry did not assert reset");
	chk_wd_hold: assert property (rst_busy_w && start_w |=> wd_cnt_reg == $past(wd_period_w)) // [R14]
		else $error("start moved watchdog during reset");
	chk_lvr_abort: assert property (lvr_w |=> state_reg == ST_IDLE && !sda_oe_o) // [R15]
		else $error("serial not aborted under low voltage");
	chk_data_nack: assert property (state_reg == ST_ACK && phase_reg == PH_DATA && sda_oe_o && !sr_tgt_reg
		&& data_cnt_reg != 4'h0 |-> wel_reg) // [R20]
		else $error("write data acknowledged without enable latch");
	chk_sr_one_byte: assert property (state_reg == ST_ACK && phase_reg == PH_DATA && sda_oe_o && sr_tgt_reg
		&& data_cnt_reg != 4'h0 |-> data_cnt_reg == 4'h1) // [R21]
		else $error("second status byte acknowledged");
	chk_por_release: assert property ($fell(rst_active_reg) |-> supply_ok_w && $past(rst_cnt_reg, 2) <= TICK_W'(1)) // [R11]
		else $error("reset released early");
	chk_idle_quiet: assert property (state_reg == ST_IDLE |-> !sda_oe_o) // [R19]
		else $error("data line driven in standby");
endmodule

// >>> verification/sss_host_model.sv
/*
 * Host-side serial master: drives the serial clock and pulls the data line
 * low through an open-drain enable.
 * Assumes the bench resolves the wire with a pull-up; bit time 200 ns.
 */
`timescale 1ns/1ps
module sss_host_model (
	output logic      scl_o,
	output logic      pull_o,
	input  wire logic sda_i
);
	// ---------------------------------------------------------------
	// bit level
	// ---------------------------------------------------------------
	// clock stands high between frames
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	// data moves 25 ns into the low phase, clear of both clock edges
	task automatic bit_t(input logic v, output logic s);
		scl_o = 1'b0;
		#25 pull_o = ~v;
		#100 scl_o = 1'b1;
		#50 s = sda_i;
		#25;
	endtask
	task automatic start();
		scl_o = 1'b0;
		#25 pull_o = 1'b0;
		#100 scl_o = 1'b1;
		#75 pull_o = 1'b1;
		#100;
	endtask
	task automatic stop();
		scl_o = 1'b0;
		#25 pull_o = 1'b1;
		#100 scl_o = 1'b1;
		#75 pull_o = 1'b0;
		#100;
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_t(d[i], s);
		end
		bit_t(1'b1, s);
		ack = ~s;
	endtask
	task automatic get(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_t(1'b1, s);
			d[i] = s;
		end
		bit_t(~ack, s);
	endtask
endmodule

// >>> verification/tb_top.sv
/*
 * Bench for the supervisor serial slave: bus tasks, serial frames through
 * the host model, a table of serial writes, then timing cases.
 * Assumes zero-wait bus answers and a 4 us crystal tick for short runs.
 */
`timescale 1ns/1ps
module tb_top;
	import sss_pkg::*;
	localparam logic [6:0] ID = 7'h2A; // arbitrary value
	localparam int         TK = 160;
	logic        clk_i, reset_i, hsel, hwrite, xtal, pull, scl, ack;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  b0, b1;
	logic [31:0] haddr, hwdata, hrdata_o, rd;
	logic        hreadyout_o, hresp_o, sda_o, sda_oe_o, reset_out_o, reset_out_oe_o;
	logic [23:0] rows [6];
	int          err_total, num_checks, n;
	wire         sda = ~(sda_oe_o | pull);

	sss_serial_slave #(.SLAVE_ID(ID), .WD_LONG_TICKS(16'h0028), .WD_MID_TICKS(16'h0014),
		.WD_SHORT_TICKS(16'h000A), .POR_TICKS(16'h0008), .NV_TICKS(16'h0005)) sss_serial_slave_inst (
		.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout_o),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .xtal_i(xtal), .reset_out_o(reset_out_o),
		.reset_out_oe_o(reset_out_oe_o));
	sss_host_model sss_host_model_inst (.scl_o(scl), .pull_o(pull), .sda_i(sda));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic edge_rdy();
		@(posedge clk_i);
		for (int k = 0; hreadyout_o !== 1'b1; k++) begin
			if (k > 50) begin
				check("hready", 32'h0, 32'h1);
				close_out();
			end
			@(posedge clk_i);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		hsize <= 3'h2;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		rd = hrdata_o;
	endtask
	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		ahb(1'b0, REG_STATUS, 32'h0);
		check("status", rd & m, e);
	endtask
	task automatic frame(input logic [7:0] a);
		// line edges land on falling clock edges, clear of the sampling edge
		@(negedge clk_i);
		sss_host_model_inst.start();
		sss_host_model_inst.put({ID, 1'b0}, ack);
		sss_host_model_inst.put(8'h00, ack);
		sss_host_model_inst.put(a, ack);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rs);
		frame(a);
		sss_host_model_inst.put(d, ack);
		if (rs) begin
			sss_host_model_inst.start();
		end
		sss_host_model_inst.stop();
	endtask
	task automatic rd2(input logic [7:0] a);
		frame(a);
		sss_host_model_inst.start();
		sss_host_model_inst.put({ID, 1'b1}, ack);
		sss_host_model_inst.get(1'b1, b0);
		sss_host_model_inst.get(1'b0, b1);
		sss_host_model_inst.stop();
	endtask
	task automatic poll();
		@(negedge clk_i);
		sss_host_model_inst.start();
		sss_host_model_inst.put({ID, 1'b0}, ack);
		sss_host_model_inst.stop();
	endtask
	task automatic nv_wait();
		for (n = 0; n < 400; n++) begin
			ahb(1'b0, REG_STATUS, 32'h0);
			if (rd[4] === 1'b0) break;
		end
		check("nv_len", n < 330, 32'h1);
		if (n == 400) close_out();
	endtask
	// counts clocks while the reset pin holds level v, bounded
	task automatic span(input logic v);
		for (n = 0; reset_out_oe_o === v && n < 3000; n++) begin
			@(posedge clk_i);
		end
	endtask

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		xtal = 1'b0;
		forever #2000 xtal = ~xtal;
	end
	initial begin
		rows = '{24'h10_00_0_0, 24'h3F_06_1_0, 24'h3F_02_1_1, 24'h3F_06_1_3, 24'h3F_00_1_0, 24'h3F_02_1_1};
		err_total = 0;
		num_checks = 0;
		reset_i = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		check("por", reset_out_oe_o, 32'h1);
		check("pins", {hresp_o, sda_o, reset_out_o}, 32'h0);
		span(1'b1);
		check("por_len", n >= 7 * TK && n <= 9 * TK, 32'h1);
		// data byte ack and latch state per serial write
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8], 1'b0);
			check("ack", ack, rows[i][4]);
			stat(32'h3, rows[i][3:0]);
		end
		rd2(8'h3F);
		check("sr_rd", b0, 32'h02);
		wr(8'h3F, 8'h06, 1'b0);
		rd2(8'h3F);
		check("sr_rd2", {b1, b0}, 32'h0006);
		wr(8'h10, 8'h08, 1'b1);
		stat(32'h13, 32'h3);
		wr(8'h10, 8'h08, 1'b0);
		stat(32'h10, 32'h10);
		poll();
		check("busy_ack", ack, 32'h0);
		nv_wait();
		stat(32'h3, 32'h1);
		rd2(8'h10);
		check("ccr", b0, 32'h08);
		// anchor the watchdog count at a known start
		poll();
		span(1'b0);
		check("wd_short", n >= 8 * TK && n <= 11 * TK, 32'h1);
		poll();
		span(1'b1);
		check("wd_rst", n >= 6 * TK && n <= 9 * TK, 32'h1);
		wr(8'h3F, 8'h06, 1'b0);
		wr(8'h10, 8'h0C, 1'b0);
		nv_wait();
		stat(32'h4, 32'h4);
		span(1'b0);
		check("wd_off", n, 32'd3000);
		frame(8'h3F);
		sss_host_model_inst.put(8'h00, ack);
		sss_host_model_inst.put(8'h00, ack);
		sss_host_model_inst.stop();
		check("sr_2nd", ack, 32'h0);
		ahb(1'b1, REG_CTRL, 32'h0);
		repeat (4) @(posedge clk_i);
		check("lv_rst", reset_out_oe_o, 32'h1);
		poll();
		check("lv_ack", ack, 32'h0);
		ahb(1'b1, REG_CTRL, 32'h3);
		wr(8'h3F, 8'h06, 1'b0);
		wr(8'h01, 8'h00, 1'b0);
		// supply drops while the cycle runs: it must still finish
		ahb(1'b1, REG_CTRL, 32'h2);
		nv_wait();
		stat(32'h20, 32'h20);
		ahb(1'b1, REG_CTRL, 32'h3);
		wr(8'h3F, 8'h06, 1'b0);
		wr(8'h03, 8'h00, 1'b0);
		nv_wait();
		stat(32'h20, 32'h0);
		ahb(1'b1, REG_CTRL, 32'h1);
		close_out();
	end
endmodule
